//--- verilog/uart_flow_map.svh
// Register offsets, field positions, reset values and fixed codes of the UART control section.
`ifndef UART_FLOW_MAP_SVH
`define UART_FLOW_MAP_SVH

// ****************************************************************
// Register offsets, as seen by the vendor requests
// ****************************************************************
`define PORT_ENABLE_OFS 10'h000
`define MODE_SELECT_OFS 10'h006
`define RESUME_CHAR_OFS 10'h007
`define PAUSE_CHAR_OFS 10'h008
`define SLEEP_LEVELS_OFS 10'h06a
`define SLEEP_BEHAVIOUR_OFS 10'h06b
`define REVISION_OFS 10'h260
`define LINK_STATUS_OFS 10'h262

// ****************************************************************
// Field positions
// ****************************************************************
`define TX_ENABLE_BIT 0
`define RX_ENABLE_BIT 1
`define HALF_DUPLEX_BIT 3
`define MODE_MSB 2
`define MODE_LSB 0
`define ADDRESS_FLAG_BIT 8

// ****************************************************************
// Reset values and write masks
// ****************************************************************
`define PORT_ENABLE_RESET 16'h0000
`define MODE_SELECT_RESET 16'h0000
`define RESUME_CHAR_RESET 16'h0011
`define PAUSE_CHAR_RESET 16'h0013
`define SLEEP_RESET 16'h0000
`define LINK_STATUS_RESET 16'h0000
`define PORT_ENABLE_MASK 16'h0003
`define MODE_SELECT_MASK 16'h000f
`define CHAR_MASK 16'h00ff
`define LINK_STATUS_MASK 16'h3f3f
`define READ_NONE 16'h0000

// Arbitrary neutral revision value.
`define REVISION_VALUE 16'h0001

`endif

//--- verilog/uart_flow_pkg.sv
// Types shared by the UART flow-control section.
package uart_flow_pkg;

  // Kinds of vendor request arriving from the host.
  typedef enum logic [2:0] {
    REQ_NONE = 3'b000,
    REQ_REG_WRITE = 3'b001,
    REQ_REG_READ = 3'b010,
    REQ_REVISION_READ = 3'b011,
    REQ_STATUS_WRITE = 3'b100,
    REQ_STATUS_READ = 3'b101
  } request_kind_t;

  // Flow-control modes held in the low field of the mode register.
  typedef enum logic [2:0] {
    MODE_NONE = 3'b000,
    MODE_HW_HANDSHAKE = 3'b001,
    MODE_SW_XON = 3'b010,
    MODE_MULTIDROP_RX = 3'b011,
    MODE_MULTIDROP_RXTX = 3'b100
  } flow_mode_t;

endpackage

//--- verilog/bit_sync.sv
// Two-flop synchroniser for a level arriving from a pin.
`timescale 1ns/1ps
`default_nettype none

module bit_sync #(
  parameter logic RESET_LEVEL = 1'b1
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic async_in,
  output logic sync_out
);

  logic meta_reg;

  // The first flop feeds only the second, so metastability settles before use.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      meta_reg <= RESET_LEVEL;
      sync_out <= RESET_LEVEL;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // bit_sync

`default_nettype wire

//--- verilog/uart_flow_control.sv
// UART enables, flow-control mode selection, half-duplex gating and address matching.
`timescale 1ns/1ps
`default_nettype none
`include "uart_flow_map.svh"

module uart_flow_control (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic req_valid,
  input wire logic [2:0] req_kind,
  input wire logic [9:0] req_addr,
  input wire logic [15:0] req_wdata,
  output logic resp_valid,
  output logic [15:0] resp_rdata,
  input wire logic rx_pin,
  output logic rx_line_gated,
  input wire logic rx_char_valid,
  input wire logic [8:0] rx_char,
  input wire logic tx_busy,
  output logic rx_data_valid,
  output logic [7:0] rx_data,
  output logic tx_enable_out,
  output logic rx_enable_out,
  output logic hw_handshake_on,
  output logic tx_permit
);

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [15:0] enable_reg;
  logic [15:0] mode_reg;
  logic [15:0] resume_reg;
  logic [15:0] pause_reg;
  logic [15:0] sleep_levels_reg;
  logic [15:0] sleep_behaviour_reg;
  logic [15:0] link_status_reg;
  logic [15:0] rdata_next;
  logic reg_write;
  logic reg_read;
  logic status_write;
  logic rx_line_sync;
  logic paused_reg;
  logic paused_next;
  logic matched_reg;
  logic matched_next;
  logic accept;
  logic forward;
  logic is_sw;
  logic is_multidrop;
  logic addr_hit;
  uart_flow_pkg::flow_mode_t mode;

  assign reg_write = req_valid && (req_kind == uart_flow_pkg::REQ_REG_WRITE);
  assign reg_read = req_valid && (req_kind == uart_flow_pkg::REQ_REG_READ);
  assign status_write = req_valid && (req_kind == uart_flow_pkg::REQ_STATUS_WRITE);
  assign mode = uart_flow_pkg::flow_mode_t'(mode_reg[`MODE_MSB:`MODE_LSB]);
  assign is_sw = (mode == uart_flow_pkg::MODE_SW_XON);
  assign is_multidrop = (mode == uart_flow_pkg::MODE_MULTIDROP_RX) ||
                        (mode == uart_flow_pkg::MODE_MULTIDROP_RXTX);

  // Register writes; the host is trusted to disable the port first, so no interlock is built.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      enable_reg <= `PORT_ENABLE_RESET;
      mode_reg <= `MODE_SELECT_RESET;
      resume_reg <= `RESUME_CHAR_RESET;
      pause_reg <= `PAUSE_CHAR_RESET;
      sleep_levels_reg <= `SLEEP_RESET;
      sleep_behaviour_reg <= `SLEEP_RESET;
    end else if (reg_write) begin
      // Upper bits of the enable, mode and character registers are masked so they read back as zero; the sleep registers keep all 16 bits.
      unique case (req_addr)
        `PORT_ENABLE_OFS: enable_reg <= req_wdata & `PORT_ENABLE_MASK;
        `MODE_SELECT_OFS: mode_reg <= req_wdata & `MODE_SELECT_MASK;
        `RESUME_CHAR_OFS: resume_reg <= req_wdata & `CHAR_MASK;
        `PAUSE_CHAR_OFS: pause_reg <= req_wdata & `CHAR_MASK;
        `SLEEP_LEVELS_OFS: sleep_levels_reg <= req_wdata;
        `SLEEP_BEHAVIOUR_OFS: sleep_behaviour_reg <= req_wdata;
        default: begin
        end
      endcase
    end
  end

  // The link status word is reachable by its own write request only.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      link_status_reg <= `LINK_STATUS_RESET;
    end else if (status_write) begin
      link_status_reg <= req_wdata & `LINK_STATUS_MASK;
    end
  end

  // Read multiplexer; revision and status hide from general reads.
  always_comb begin
    rdata_next = `READ_NONE;
    if (reg_read) begin
      unique case (req_addr)
        `PORT_ENABLE_OFS: rdata_next = enable_reg;
        `MODE_SELECT_OFS: rdata_next = mode_reg;
        `RESUME_CHAR_OFS: rdata_next = resume_reg;
        `PAUSE_CHAR_OFS: rdata_next = pause_reg;
        `SLEEP_LEVELS_OFS: rdata_next = sleep_levels_reg;
        `SLEEP_BEHAVIOUR_OFS: rdata_next = sleep_behaviour_reg;
        default: rdata_next = `READ_NONE;
      endcase
    end else if (req_valid && (req_kind == uart_flow_pkg::REQ_REVISION_READ)) begin
      rdata_next = `REVISION_VALUE;
    end else if (req_valid && (req_kind == uart_flow_pkg::REQ_STATUS_READ)) begin
      rdata_next = link_status_reg;
    end
  end

  // Every request of a kind other than REQ_NONE gets a one-cycle answer on the next edge.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      resp_valid <= 1'b0;
      resp_rdata <= `READ_NONE;
    end else begin
      resp_valid <= req_valid && (req_kind != uart_flow_pkg::REQ_NONE);
      resp_rdata <= rdata_next;
    end
  end

  // ****************************************************************
  // Receive path
  // ****************************************************************
  bit_sync #(
    .RESET_LEVEL(1'b1)
  ) rx_pin_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .async_in(rx_pin),
    .sync_out(rx_line_sync)
  );

  // In half-duplex the line shows idle while sending, so own echoes never frame.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rx_line_gated <= 1'b1;
    end else begin
      rx_line_gated <= (mode_reg[`HALF_DUPLEX_BIT] && tx_busy) ? 1'b1 : rx_line_sync;
    end
  end

  // Classify each received character and update pause and match state.
  always_comb begin
    accept = rx_char_valid && enable_reg[`RX_ENABLE_BIT] &&
             !(mode_reg[`HALF_DUPLEX_BIT] && tx_busy);
    addr_hit = (rx_char[7:0] == resume_reg[7:0]) || (rx_char[7:0] == pause_reg[7:0]);
    forward = accept;
    paused_next = is_sw ? paused_reg : 1'b0;
    matched_next = is_multidrop ? matched_reg : 1'b0;
    if (accept && is_sw) begin
      // Flow characters are consumed and not handed on.
      if (rx_char[7:0] == pause_reg[7:0]) begin
        paused_next = 1'b1;
        forward = 1'b0;
      end else if (rx_char[7:0] == resume_reg[7:0]) begin
        paused_next = 1'b0;
        forward = 1'b0;
      end
    end else if (accept && is_multidrop) begin
      if (rx_char[`ADDRESS_FLAG_BIT]) begin
        // A foreign address drops the match, so data for other nodes is skipped.
        matched_next = addr_hit;
        forward = 1'b0;
      end else begin
        forward = matched_reg;
      end
    end
  end

  // Pause and match flags; received characters move them, and leaving their mode clears them.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      paused_reg <= 1'b0;
      matched_reg <= 1'b0;
    end else begin
      paused_reg <= paused_next;
      matched_reg <= matched_next;
    end
  end

  // Forwarded data leave the block one cycle after arrival.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rx_data_valid <= 1'b0;
      rx_data <= 8'h00;
    end else begin
      rx_data_valid <= forward;
      rx_data <= rx_char[7:0];
    end
  end

  // ****************************************************************
  // Transmit control and mode outputs
  // ****************************************************************
  // The handshake pin pair is chosen elsewhere, so only the mode flag leaves here.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tx_enable_out <= 1'b0;
      rx_enable_out <= 1'b0;
      hw_handshake_on <= 1'b0;
      tx_permit <= 1'b0;
    end else begin
      tx_enable_out <= enable_reg[`TX_ENABLE_BIT];
      rx_enable_out <= enable_reg[`RX_ENABLE_BIT];
      hw_handshake_on <= (mode == uart_flow_pkg::MODE_HW_HANDSHAKE);
      tx_permit <= enable_reg[`TX_ENABLE_BIT] && !(is_sw && paused_reg) &&
                   !((mode == uart_flow_pkg::MODE_MULTIDROP_RXTX) && !matched_reg);
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  sequence enable_write_s;
    reg_write && (req_addr == `PORT_ENABLE_OFS);
  endsequence

  sequence pause_seen_s;
    accept && is_sw && (rx_char[7:0] == pause_reg[7:0]) && !reg_write;
  endsequence

  rx_enable_follow_a: assert property (enable_write_s |-> ##2
    rx_enable_out == $past(req_wdata[`RX_ENABLE_BIT], 2))
    else $error("Receiver enable did not follow the write.");

  tx_enable_follow_a: assert property (enable_write_s |-> ##2
    tx_enable_out == $past(req_wdata[`TX_ENABLE_BIT], 2))
    else $error("Transmitter enable did not follow the write.");

  half_duplex_drop_a: assert property (mode_reg[`HALF_DUPLEX_BIT] && tx_busy &&
    rx_char_valid |=> !rx_data_valid && rx_line_gated)
    else $error("Data passed while half-duplex transmission ran.");

  handshake_flag_a: assert property ((mode == uart_flow_pkg::MODE_HW_HANDSHAKE)
    |=> hw_handshake_on)
    else $error("Handshake flag missing in handshake mode.");

  match_gate_rx_a: assert property (is_multidrop && !matched_reg && rx_char_valid &&
    !rx_char[`ADDRESS_FLAG_BIT] |=> !rx_data_valid)
    else $error("Unaddressed data passed in multidrop mode.");

  match_gate_tx_a: assert property ((mode == uart_flow_pkg::MODE_MULTIDROP_RXTX) &&
    !matched_reg |=> !tx_permit)
    else $error("Transmit permitted without address match.");

  pause_halts_tx_a: assert property (pause_seen_s |=> paused_reg ##1 !tx_permit)
    else $error("Pause character did not halt transmission.");

  resume_clears_a: assert property (accept && is_sw && paused_reg &&
    (rx_char[7:0] == resume_reg[7:0]) && (rx_char[7:0] != pause_reg[7:0]) && !reg_write
    |=> !paused_reg)
    else $error("Resume character did not clear the pause.");

  revision_hidden_a: assert property (reg_read && (req_addr == `REVISION_OFS)
    |=> resp_valid && (resp_rdata == `READ_NONE))
    else $error("Revision visible to a general read.");

  address_match_a: assert property (accept && is_multidrop && rx_char[`ADDRESS_FLAG_BIT] &&
    (rx_char[7:0] == resume_reg[7:0]) && !reg_write |=> matched_reg)
    else $error("Unicast address did not set the match.");

  rx_off_drop_a: assert property (rx_char_valid && !enable_reg[`RX_ENABLE_BIT]
    |=> !rx_data_valid)
    else $error("Data passed while the receiver was off.");

  status_hidden_a: assert property (reg_read && (req_addr == `LINK_STATUS_OFS)
    |=> resp_valid && (resp_rdata == `READ_NONE))
    else $error("Link status visible to a general read.");

  status_write_a: assert property (status_write |=>
    link_status_reg == ($past(req_wdata) & `LINK_STATUS_MASK))
    else $error("Link status write did not land.");

  revision_answer_a: assert property (req_valid &&
    (req_kind == uart_flow_pkg::REQ_REVISION_READ) |=> resp_rdata == `REVISION_VALUE)
    else $error("Revision request answered wrongly.");

endmodule // uart_flow_control

`default_nettype wire

//--- verif/remote_node.sv
// Behavioural remote serial node that feeds received characters and the receive pin.
`timescale 1ns/1ps
`default_nettype none

module remote_node (
  input wire logic clk_sys,
  output logic rx_pin,
  output logic rx_char_valid,
  output logic [8:0] rx_char
);
  // The line idles high, as an undriven serial line does.
  initial begin
    rx_pin = 1'b1;
    rx_char_valid = 1'b0;
    rx_char = 9'h000;
  end

  // One character per call; the ninth bit marks an address character.
  task automatic send(input logic [8:0] c);
    @(posedge clk_sys);
    rx_char_valid <= 1'b1;
    rx_char <= c;
    @(posedge clk_sys);
    rx_char_valid <= 1'b0;
    rx_char <= ~c; // The old value must never look valid.
  endtask

  // Moves the receive pin to a new level.
  task automatic pin(input logic v);
    @(posedge clk_sys);
    rx_pin <= v;
  endtask
endmodule // remote_node
`default_nettype wire

//--- verif/tb.sv
// Self-checking bench of the UART control section with queued expectations.
`timescale 1ns/1ps
`default_nettype none
`include "uart_flow_map.svh"

module tb;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic req_valid = 1'b0;
  logic [2:0] req_kind = 3'h0;
  logic [9:0] req_addr = 10'h000;
  logic [15:0] req_wdata = 16'h0000;
  logic tx_busy = 1'b0;
  logic rx_pin, rx_char_valid, resp_valid, rx_line_gated, rx_data_valid;
  logic tx_enable_out, rx_enable_out, hw_handshake_on, tx_permit;
  logic [8:0] rx_char;
  logic [15:0] resp_rdata;
  logic [7:0] rx_data;
  integer seed = 32'h3179_1aa9;
  int failures = 0;
  int checks = 0;
  logic [15:0] rq[$];
  logic [7:0] dq[$];

  // ****************************************************************
  // Clock, design and remote node
  // ****************************************************************
  always #25 clk_sys = ~clk_sys;

  uart_flow_control uart_flow_control_inst (.clk_sys(clk_sys), .srst(srst),
    .req_valid(req_valid), .req_kind(req_kind), .req_addr(req_addr),
    .req_wdata(req_wdata), .resp_valid(resp_valid), .resp_rdata(resp_rdata),
    .rx_pin(rx_pin), .rx_line_gated(rx_line_gated), .rx_char_valid(rx_char_valid),
    .rx_char(rx_char), .tx_busy(tx_busy), .rx_data_valid(rx_data_valid),
    .rx_data(rx_data), .tx_enable_out(tx_enable_out), .rx_enable_out(rx_enable_out),
    .hw_handshake_on(hw_handshake_on), .tx_permit(tx_permit));

  remote_node remote_node_inst (.clk_sys(clk_sys), .rx_pin(rx_pin),
    .rx_char_valid(rx_char_valid), .rx_char(rx_char));

  // ****************************************************************
  // Comparison, verdict and drivers
  // ****************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    if (failures == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // One vendor request; every request kind except REQ_NONE is answered once.
  task automatic req(input logic [2:0] k, input logic [9:0] a, input logic [15:0] d,
                     input logic [15:0] e);
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_kind <= k;
    req_addr <= a;
    req_wdata <= d;
    rq.push_back(e);
    @(posedge clk_sys);
    req_valid <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    req(uart_flow_pkg::REQ_REG_WRITE, a, d, `READ_NONE);
  endtask

  task automatic rd(input logic [9:0] a, input logic [15:0] e);
    req(uart_flow_pkg::REQ_REG_READ, a, 16'h0000, e);
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // Notes the expected byte before the character leaves the node.
  task automatic chr(input logic [8:0] c, input logic f);
    if (f) dq.push_back(c[7:0]);
    remote_node_inst.send(c);
  endtask

  // The port is disabled around every configuration write.
  task automatic setup(input logic [15:0] m);
    wr(`PORT_ENABLE_OFS, 16'h0000);
    wr(`MODE_SELECT_OFS, m);
    wr(`PORT_ENABLE_OFS, 16'h0003);
  endtask

  // Answers and forwarded bytes are matched against the oldest note.
  always @(posedge clk_sys) begin
    if (resp_valid === 1'b1) begin
      if (rq.size() > 0) chk(resp_rdata, rq.pop_front());
      else chk(16'h0001, 16'h0000);
    end
    if (rx_data_valid === 1'b1) begin
      if (dq.size() > 0) chk(rx_data, dq.pop_front());
      else chk(16'h0001, 16'h0000);
    end
  end

  // A hung run is cut short.
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    test_done();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [31:0] r;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    rd(`PORT_ENABLE_OFS, `PORT_ENABLE_RESET);
    rd(`MODE_SELECT_OFS, `MODE_SELECT_RESET);
    rd(`RESUME_CHAR_OFS, `RESUME_CHAR_RESET);
    rd(`PAUSE_CHAR_OFS, `PAUSE_CHAR_RESET);
    rd(`SLEEP_BEHAVIOUR_OFS, `SLEEP_RESET);
    wr(`SLEEP_LEVELS_OFS, 16'ha5a5);
    rd(`SLEEP_LEVELS_OFS, 16'ha5a5);
    rd(`REVISION_OFS, `READ_NONE);
    req(uart_flow_pkg::REQ_REVISION_READ, `REVISION_OFS, 16'h0000, `REVISION_VALUE);
    req(uart_flow_pkg::REQ_STATUS_WRITE, `LINK_STATUS_OFS, 16'hffff, `READ_NONE);
    wr(`LINK_STATUS_OFS, 16'h0000);
    req(uart_flow_pkg::REQ_STATUS_READ, `LINK_STATUS_OFS, 16'h0000, `LINK_STATUS_MASK);
    rd(`LINK_STATUS_OFS, `READ_NONE);
    rd(10'h3ff, `READ_NONE);
    // A request of no kind is never answered, so its note is withdrawn at once.
    req(uart_flow_pkg::REQ_NONE, `PORT_ENABLE_OFS, 16'h0000, `READ_NONE);
    void'(rq.pop_back());
    for (int i = 0; i < 4; i++) begin
      wr(`PORT_ENABLE_OFS, 16'(i));
      wait_n(2);
      chk(tx_enable_out, i[0]);
      chk(rx_enable_out, i[1]);
    end
    // Receiver off drops characters.
    wr(`PORT_ENABLE_OFS, 16'h0001);
    chr(9'h041, 1'b0);
    for (int m = 0; m < 5; m++) begin
      setup(16'(m));
      wait_n(2);
      chk(hw_handshake_on, m == 1);
      chk(tx_permit, m != 4);
      rd(`MODE_SELECT_OFS, 16'(m));
    end
    // Plain mode passes every byte, flow characters included.
    setup(16'h0000);
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      chr({1'b0, r[7:0]}, 1'b1);
    end
    chr(9'h013, 1'b1);
    // Software flow control with a reprogrammed resume character.
    wr(`PORT_ENABLE_OFS, 16'h0000);
    wr(`RESUME_CHAR_OFS, 16'h0055);
    setup(16'h0002);
    chr(9'h041, 1'b1);
    chr(9'h013, 1'b0);
    wait_n(3);
    chk(tx_permit, 1'b0);
    chr(9'h011, 1'b1);
    wait_n(3);
    chk(tx_permit, 1'b0);
    chr(9'h055, 1'b0);
    wait_n(3);
    chk(tx_permit, 1'b1);
    // Receive-only address matching against the unicast address.
    setup(16'h0003);
    chr(9'h041, 1'b0);
    chr(9'h155, 1'b0);
    chr(9'h042, 1'b1);
    chr(9'h177, 1'b0);
    chr(9'h043, 1'b0);
    wait_n(3);
    chk(tx_permit, 1'b1);
    // Both directions wait for the multicast address.
    setup(16'h0004);
    chr(9'h044, 1'b0);
    chr(9'h113, 1'b0);
    wait_n(3);
    chk(tx_permit, 1'b1);
    chr(9'h045, 1'b1);
    chr(9'h101, 1'b0);
    wait_n(3);
    chk(tx_permit, 1'b0);
    // Half duplex ignores the line while the transmitter is busy.
    setup(16'h0008);
    @(posedge clk_sys);
    tx_busy <= 1'b1;
    chr(9'h061, 1'b0);
    remote_node_inst.pin(1'b0);
    wait_n(4);
    chk(rx_line_gated, 1'b1);
    @(posedge clk_sys);
    tx_busy <= 1'b0;
    wait_n(4);
    chk(rx_line_gated, 1'b0);
    chr(9'h062, 1'b1);
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      remote_node_inst.pin(r[0]);
      wait_n(4);
      chk(rx_line_gated, r[0]);
    end
    for (int i = 0; i < 20 && (rq.size() + dq.size()) > 0; i++) @(posedge clk_sys);
    if ((rq.size() + dq.size()) > 0) failures++;
    test_done();
  end
endmodule // tb
`default_nettype wire
